// ### hw/lfs_pkg.sv
// Package of constants and types for the laser fault status indicator
package lfs_pkg;
    localparam int unsigned CLK_HZ          = 100_000_000;
    localparam int unsigned ENABLE_DELAY_MS = 5000;
    localparam int unsigned PAUSE_MS        = 500;
    localparam int unsigned BLINK_ON_MS     = 250;
    localparam int unsigned BLINK_OFF_MS    = 250;
    localparam int unsigned FLASH_HALF_MS   = 250;
    localparam int unsigned MS_CYCLES       = CLK_HZ / 1000;
    localparam int unsigned ENABLE_DELAY_CYC = ENABLE_DELAY_MS * MS_CYCLES;
    localparam int unsigned PAUSE_CYC       = PAUSE_MS * MS_CYCLES;
    localparam int unsigned BLINK_ON_CYC    = BLINK_ON_MS * MS_CYCLES;
    localparam int unsigned BLINK_OFF_CYC   = BLINK_OFF_MS * MS_CYCLES;
    localparam int unsigned FLASH_HALF_CYC  = FLASH_HALF_MS * MS_CYCLES;
    localparam int unsigned EMIT_MIN_US     = 2;
    localparam int unsigned EMIT_MIN_CYC    = EMIT_MIN_US * (CLK_HZ / 1_000_000);
    localparam int unsigned EMIT_HOLD_MS    = 100;
    localparam int unsigned EMIT_HOLD_CYC   = EMIT_HOLD_MS * MS_CYCLES;
    localparam int          CNT_W           = 32;
    localparam int          SYNC_W          = 3;

    // Register map
    localparam logic [11:0] ADDR_STATUS  = 12'h000;
    localparam logic [11:0] ADDR_MASK    = 12'h004;
    localparam logic [11:0] ADDR_FAULTS  = 12'h008;
    localparam logic [11:0] ADDR_CTRL    = 12'h00C;
    localparam int          NFAULT       = 5;
    localparam int          FB_OVER_TEMP = 0;
    localparam int          FB_UNDER_V   = 1;
    localparam int          FB_OVER_V    = 2;
    localparam int          FB_SUPPLY    = 3;
    localparam int          FB_PWDRIVE   = 4;
    localparam int          EV_ENABLE    = 5;
    localparam int          NEVENT       = 6;
    localparam int          CTRL_FORCE_OFF = 0;
    localparam logic [2:0]  CODE_UNDER_V = 3'h1;
    localparam logic [2:0]  CODE_OVER_V  = 3'h2;
    localparam logic [2:0]  CODE_SUPPLY  = 3'h3;

    typedef enum logic [2:0] {
        DISP_NONE,
        DISP_FLASH_READY,
        DISP_FLASH_BOTH,
        DISP_CODE_POWER
    } lfs_disp_t;
endpackage

// ### hw/lfs_sync_if.sv
// Interface carrying one synchronised input between modules
`timescale 1ns/1ns
interface lfs_sync_if;
    logic raw;
    logic level;
    modport src (input level, output raw);
    modport syn (input raw, output level);
endinterface

// ### hw/lfs_sync.sv
// Three-stage synchroniser with agreement check
`timescale 1ns/1ns
module lfs_sync
    import lfs_pkg::*;
(
    input  wire logic hclk,
    input  wire logic hresetn,
    lfs_sync_if.syn   s
);
    logic [SYNC_W-1:0] sh_q;
    logic [SYNC_W-1:0] sh_d;
    logic              lvl_q;
    logic              lvl_d;

    always_comb
    begin
        sh_d  = {sh_q[SYNC_W-2:0], s.raw};
        lvl_d = lvl_q;
        // First stage feeds only the second
        if (sh_q[1] == sh_q[2])
        begin
            lvl_d = sh_q[2];
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            sh_q  <= '0;
            lvl_q <= 1'b0;
        end
        else
        begin
            sh_q  <= sh_d;
            lvl_q <= lvl_d;
        end
    end

    assign s.level = lvl_q;
endmodule

// ### hw/lfs_top.sv
// Laser status lamps, fault latching, blink codes and emission gating
//
// The placing of the registers and register access over AHB-Lite are this design's own decisions.
`timescale 1ns/1ns
// Overview of operation
// - Power lamp steady on when supplied and no blinking fault latched.
// - Enable lights ready lamp; tickle passes to RF after five seconds.
// - Emission lamp lights when command pulses are long enough to emission_indicator.
// - Coded faults blink on power lamp, half-second pause, then repeat.
// - Faults stay latched until power cycle resets the logic.
// - Over temperature flashes ready lamp, power lamp stays steady.
// - Over temperature clears only if cool at reset; ready then steady.
// - Under voltage at or below threshold: one power lamp blink.
// - Over voltage at or above threshold: two power lamp blinks.
// - After voltage fault cleared, power and ready lamps light normally.
// - Supply sense fault: three power lamp blinks.
// - Pulse-width or control board fault flashes both lamps.
module lfs_top
    import lfs_pkg::*;
#(
    parameter int unsigned ENABLE_CYC = ENABLE_DELAY_CYC,
    parameter int unsigned PAUSE_C    = PAUSE_CYC,
    parameter int unsigned ON_C       = BLINK_ON_CYC,
    parameter int unsigned OFF_C      = BLINK_OFF_CYC,
    parameter int unsigned FLASH_C    = FLASH_HALF_CYC,
    parameter int unsigned EMIT_HOLD_C = EMIT_HOLD_CYC
)
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        emission_enable,
    input  wire logic        pw_command,
    input  wire logic        tickle_in,
    input  wire logic        over_temp,
    input  wire logic        under_voltage,
    input  wire logic        over_voltage,
    input  wire logic        supply_sense_fault,
    input  wire logic        pw_drive_fault,
    output logic             power_indicator,
    output logic             ready_indicator,
    output logic             emission_indicator,
    output logic             rf_drive,
    output logic             irq
);
    import lfs_pkg::*;

    localparam int NIN = 7;
    logic [NIN-1:0] raw_in;
    logic [NIN-1:0] syn_in;
    assign raw_in = {pw_drive_fault, supply_sense_fault, over_voltage, under_voltage,
                     over_temp, pw_command, emission_enable};

    generate
        for (genvar g = 0; g < NIN; g++)
        begin : g_sync
            lfs_sync_if sif ();
            assign sif.raw = raw_in[g];
            assign syn_in[g] = sif.level;
            lfs_sync u_sync (.hclk(hclk), .hresetn(hresetn), .s(sif));
        end
    endgenerate

    logic en_s;
    logic pw_s;
    logic [NFAULT-1:0] cond;
    assign en_s = syn_in[0];
    assign pw_s = syn_in[1];
    assign cond = syn_in[6:2];

    // Fault latches; only hresetn (power cycle) clears them
    logic [NFAULT-1:0] flt_q;
    logic [NFAULT-1:0] flt_d;
    always_comb
    begin
        flt_d = flt_q | cond;
    end

    // Fault display selection by priority
    lfs_disp_t    disp;
    logic [2:0]   code_n;
    always_comb
    begin
        disp   = DISP_NONE;
        code_n = 3'h0;
        if (flt_q[FB_PWDRIVE])
        begin
            disp = DISP_FLASH_BOTH;
        end
        else if (flt_q[FB_SUPPLY])
        begin
            disp   = DISP_CODE_POWER;
            code_n = CODE_SUPPLY;
        end
        else if (flt_q[FB_OVER_V])
        begin
            disp   = DISP_CODE_POWER;
            code_n = CODE_OVER_V;
        end
        else if (flt_q[FB_UNDER_V])
        begin
            disp   = DISP_CODE_POWER;
            code_n = CODE_UNDER_V;
        end
        else if (flt_q[FB_OVER_TEMP])
        begin
            disp = DISP_FLASH_READY;
        end
    end

    // Blink sequencer: code blinks then pause, or continuous flash
    typedef enum logic [1:0] {SEQ_ON, SEQ_OFF, SEQ_PAUSE} lfs_seq_t;
    lfs_seq_t          seq_q;
    lfs_seq_t          seq_d;
    logic [CNT_W-1:0]  tm_q;
    logic [CNT_W-1:0]  tm_d;
    logic [2:0]        bl_q;
    logic [2:0]        bl_d;
    logic              fl_q;
    logic              fl_d;
    always_comb
    begin
        seq_d = seq_q;
        tm_d  = tm_q + 32'h1;
        bl_d  = bl_q;
        fl_d  = fl_q;
        if (disp == DISP_FLASH_READY || disp == DISP_FLASH_BOTH)
        begin
            if (tm_q >= CNT_W'(FLASH_C - 1))
            begin
                tm_d = '0;
                fl_d = ~fl_q;
            end
        end
        else if (disp == DISP_CODE_POWER)
        begin
            case (seq_q)
                SEQ_ON:
                begin
                    if (tm_q >= CNT_W'(ON_C - 1))
                    begin
                        tm_d  = '0;
                        seq_d = SEQ_OFF;
                        bl_d  = bl_q + 3'h1;
                    end
                end
                SEQ_OFF:
                begin
                    if (tm_q >= CNT_W'(OFF_C - 1))
                    begin
                        tm_d  = '0;
                        seq_d = (bl_q >= code_n) ? SEQ_PAUSE : SEQ_ON;
                    end
                end
                SEQ_PAUSE:
                begin
                    if (tm_q >= CNT_W'(PAUSE_C - 1))
                    begin
                        tm_d  = '0;
                        bl_d  = 3'h0;
                        seq_d = SEQ_ON;
                    end
                end
                default:
                begin
                    seq_d = SEQ_ON;
                end
            endcase
        end
        else
        begin
            tm_d  = '0;
            bl_d  = 3'h0;
            seq_d = SEQ_ON;
        end
    end

    // Enable delay, tickle pass-through and emission detect
    logic [CNT_W-1:0] dly_q;
    logic [CNT_W-1:0] dly_d;
    logic             armed;
    logic [CNT_W-1:0] pwc_q;
    logic [CNT_W-1:0] pwc_d;
    logic [CNT_W-1:0] eh_q;
    logic [CNT_W-1:0] eh_d;
    logic             force_off_q;
    always_comb
    begin
        dly_d = '0;
        if (en_s && flt_q == '0)
        begin
            dly_d = (dly_q >= CNT_W'(ENABLE_CYC)) ? dly_q : dly_q + 32'h1;
        end
        pwc_d = pw_s ? ((pwc_q == '1) ? pwc_q : pwc_q + 32'h1) : '0;
        eh_d  = (eh_q == '0) ? eh_q : eh_q - 32'h1;
        // Short command pulses do not emission_indicator; require minimum width
        if (armed && pwc_q >= CNT_W'(EMIT_MIN_CYC))
        begin
            eh_d = CNT_W'(EMIT_HOLD_C);
        end
    end
    assign armed = (dly_q >= CNT_W'(ENABLE_CYC)) && !force_off_q;

    // Register file
    logic [NEVENT-1:0] st_q;
    logic [NEVENT-1:0] st_d;
    logic [NEVENT-1:0] mask_q;
    logic [NEVENT-1:0] mask_d;
    logic              force_off_d;
    logic              dp_wr_q;
    logic [11:0]       dp_addr_q;
    logic              ap_go;
    logic              en_prev_q;
    logic [NEVENT-1:0] ev;
    assign ap_go = hsel && hready && htrans[1];
    assign ev    = {armed && !en_prev_q, cond & ~flt_q};

    always_comb
    begin
        st_d        = st_q;
        mask_d      = mask_q;
        force_off_d = force_off_q;
        if (dp_wr_q)
        begin
            case (dp_addr_q)
                ADDR_STATUS: st_d = st_q & ~hwdata[NEVENT-1:0];
                ADDR_MASK:   mask_d = hwdata[NEVENT-1:0];
                ADDR_CTRL:   force_off_d = hwdata[CTRL_FORCE_OFF];
                default:     st_d = st_q;
            endcase
        end
        // Set wins over clear
        st_d = st_d | ev;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            flt_q       <= '0;
            seq_q       <= SEQ_ON;
            tm_q        <= '0;
            bl_q        <= 3'h0;
            fl_q        <= 1'b0;
            dly_q       <= '0;
            pwc_q       <= '0;
            eh_q        <= '0;
            st_q        <= '0;
            mask_q      <= '0;
            force_off_q <= 1'b0;
            dp_wr_q     <= 1'b0;
            dp_addr_q   <= '0;
            en_prev_q   <= 1'b0;
            hrdata      <= '0;
        end
        else
        begin
            flt_q       <= flt_d;
            seq_q       <= seq_d;
            tm_q        <= tm_d;
            bl_q        <= bl_d;
            fl_q        <= fl_d;
            dly_q       <= dly_d;
            pwc_q       <= pwc_d;
            eh_q        <= eh_d;
            st_q        <= st_d;
            mask_q      <= mask_d;
            force_off_q <= force_off_d;
            dp_wr_q     <= ap_go && hwrite;
            dp_addr_q   <= haddr[11:0];
            en_prev_q   <= armed;
            hrdata      <= '0;
            if (ap_go && !hwrite)
            begin
                case (haddr[11:0])
                    ADDR_STATUS: hrdata <= 32'(st_q);
                    ADDR_MASK:   hrdata <= 32'(mask_q);
                    ADDR_FAULTS: hrdata <= 32'(flt_q);
                    ADDR_CTRL:   hrdata <= 32'(force_off_q);
                    default:     hrdata <= '0;
                endcase
            end
        end
    end

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign irq       = |(st_q & mask_q);

    // Lamp outputs
    always_comb
    begin
        power_indicator = 1'b1;
        ready_indicator = en_s;
        case (disp)
            DISP_FLASH_READY: ready_indicator = fl_q;
            DISP_FLASH_BOTH:
            begin
                ready_indicator = fl_q;
                power_indicator = fl_q;
            end
            DISP_CODE_POWER:  power_indicator = (seq_q == SEQ_ON);
            default:          power_indicator = 1'b1;
        endcase
    end
    assign emission_indicator = (eh_q != '0);
    assign rf_drive = armed && (flt_q == '0) && tickle_in;
endmodule

// ### bench/lfs_checker_assertions.sv
// Concurrent checks on the status lamp block ports
`timescale 1ns/1ns
module lfs_checker
    import lfs_pkg::*;
#(
    parameter int unsigned ENABLE_CYC = 20
)
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic emission_enable,
    input wire logic pw_command,
    input wire logic tickle_in,
    input wire logic over_temp,
    input wire logic under_voltage,
    input wire logic over_voltage,
    input wire logic supply_sense_fault,
    input wire logic pw_drive_fault,
    input wire logic power_indicator,
    input wire logic ready_indicator,
    input wire logic emission_indicator,
    input wire logic rf_drive
);
    logic [31:0] en_q;
    logic [31:0] pw_q;
    logic        lo_q;
    logic [4:0]  seen_q;
    logic [3:0]  age_q;
    logic [4:0]  flt;
    assign flt = {pw_drive_fault, supply_sense_fault, over_voltage, under_voltage, over_temp};
    // Raw inputs lead the synced ones, so raw counts are upper bounds
    always_ff @(posedge hclk or negedge hresetn)
        if (!hresetn)
        begin
            en_q   <= 32'h0;
            pw_q   <= 32'h0;
            lo_q   <= 1'b1;
            seen_q <= 5'h00;
            age_q  <= 4'h0;
        end
        else
        begin
            en_q   <= emission_enable ? en_q + 32'h1 : 32'h0;
            pw_q   <= pw_command ? (lo_q ? 32'h1 : pw_q + 32'h1) : pw_q;
            lo_q   <= !pw_command;
            seen_q <= seen_q | flt;
            age_q  <= (|seen_q && age_q != 4'hF) ? age_q + 4'h1 : age_q;
        end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    bus_okay_a: assert property (hreadyout && !hresp) else $error("bus not ready or not okay");
    rf_gate_a: assert property (rf_drive |-> tickle_in)
        else $error("rf without tickle");
    rf_delay_a: assert property (rf_drive |-> en_q >= ENABLE_CYC)
        else $error("rf before enable delay");
    rf_fault_a: assert property (age_q >= 4'h8 |-> !rf_drive)
        else $error("rf while fault latched");
    pwr_steady_a: assert property (seen_q[4:1] == 4'h0 |-> power_indicator)
        else $error("power lamp not steady");
    rdy_off_a: assert property ((!emission_enable)[*8] ##0 (seen_q == 5'h00) |-> !ready_indicator)
        else $error("ready lamp without enable");
    emit_min_a: assert property ($rose(emission_indicator) |-> pw_q >= EMIT_MIN_CYC)
        else $error("emission lamp on short pulse");
    both_flash_a: assert property (seen_q[4] && age_q >= 4'h8 |-> ##[1:8] $changed(power_indicator))
        else $error("power lamp not flashing");
    temp_flash_a: assert property (seen_q == 5'h01 && age_q >= 4'h8 |-> ##[1:8] $changed(ready_indicator))
        else $error("ready lamp not flashing");
endmodule
bind lfs_top lfs_checker #(.ENABLE_CYC(ENABLE_CYC)) lfs_checker_inst (
    .hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp),
    .emission_enable(emission_enable), .pw_command(pw_command), .tickle_in(tickle_in),
    .over_temp(over_temp), .under_voltage(under_voltage), .over_voltage(over_voltage),
    .supply_sense_fault(supply_sense_fault), .pw_drive_fault(pw_drive_fault),
    .power_indicator(power_indicator), .ready_indicator(ready_indicator),
    .emission_indicator(emission_indicator), .rf_drive(rf_drive));

// ### bench/lfs_host_model.sv
// Host machine model: enable level, tickle train, pulse-width command
`timescale 1ns/1ns
module lfs_host_model
(
    input  wire logic hclk,
    input  wire logic hresetn,
    output logic      emission_enable,
    output logic      pw_command,
    output logic      tickle_in
);
    logic tick_q;
    initial
    begin
        emission_enable = 1'b0;
        pw_command = 1'b0;
    end
    // Tickle only while enabled, no stale pulses left at the gate
    assign tickle_in = tick_q & emission_enable;
    always_ff @(posedge hclk or negedge hresetn)
        if (!hresetn)
            tick_q <= 1'b0;
        else
            tick_q <= ~tick_q;
    task automatic set_enable(input logic v);
        @(posedge hclk);
        emission_enable <= v;
    endtask
    task automatic pw_pulse(input int n);
        @(posedge hclk);
        pw_command <= 1'b1;
        repeat (n) @(posedge hclk);
        pw_command <= 1'b0;
    endtask
endmodule

// ### bench/lfs_top_tb_top.sv
// Testbench: lamps, blink codes, gating and registers
`timescale 1ns/1ns
module lfs_top_tb_top;
    import lfs_pkg::*;
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
    logic        emission_enable, pw_command, tickle_in, rf_drive;
    logic        power_indicator, ready_indicator, emission_indicator;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [4:0]  flt;
    int          err_total = 0;
    int          cmp_count = 0;
    int          pf, rdf, rfc;
    logic [4:0]  fv [6] = '{5'h01, 5'h02, 5'h04, 5'h08, 5'h10, 5'h0A};
    int          pv [6] = '{0, 12, 16, 18, 30, 18};
    int          rv [6] = '{30, 0, 0, 0, 30, 0};
    lfs_top #(.ENABLE_CYC(20), .PAUSE_C(10), .ON_C(5), .OFF_C(5), .FLASH_C(4),
        .EMIT_HOLD_C(8)) lfs_top_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .emission_enable(emission_enable), .pw_command(pw_command), .tickle_in(tickle_in),
        .over_temp(flt[0]), .under_voltage(flt[1]), .over_voltage(flt[2]),
        .supply_sense_fault(flt[3]), .pw_drive_fault(flt[4]),
        .power_indicator(power_indicator), .ready_indicator(ready_indicator),
        .emission_indicator(emission_indicator), .rf_drive(rf_drive), .irq(irq));
    lfs_host_model lfs_host_model_inst (.hclk(hclk), .hresetn(hresetn),
        .emission_enable(emission_enable), .pw_command(pw_command), .tickle_in(tickle_in));
    initial
    begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e)
        begin
            $display("[ERR] %s expected %h seen %h", n, e, g);
            err_total++;
        end
    endtask
    task automatic ahb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {20'h00000, a};
        hwrite <= wr;
        hsize <= 3'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    // Counts lamp falls and rf pulses, sampled mid-cycle
    task automatic cnt(input int n);
        logic pp;
        logic pr;
        pf = 0;
        rdf = 0;
        rfc = 0;
        pp = power_indicator;
        pr = ready_indicator;
        repeat (n)
        begin
            @(negedge hclk);
            pf += int'(pp && !power_indicator);
            rdf += int'(pr && !ready_indicator);
            rfc += int'(rf_drive);
            pp = power_indicator;
            pr = ready_indicator;
        end
    endtask
    task automatic do_reset();
        lfs_host_model_inst.set_enable(1'b0);
        hresetn <= 1'b0;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
    endtask
    task automatic normal();
        do_reset();
        cnt(10);
        chk("power", 32'h1, {31'h0, power_indicator});
        chk("ready off", 32'h0, {31'h0, ready_indicator});
        lfs_host_model_inst.set_enable(1'b1);
        cnt(12);
        chk("early rf", 32'h0, 32'(rfc));
        cnt(20);
        cnt(20);
        chk("rf passes", 32'h1, {31'h0, rfc > 0});
        chk("ready steady", 32'h0, 32'(rdf));
        chk("ready on", 32'h1, {31'h0, ready_indicator});
        ahb(1'b0, ADDR_STATUS, 32'h0);
        chk("status", 32'h20, rd);
        ahb(1'b1, ADDR_MASK, 32'h20);
        cnt(2);
        chk("irq set", 32'h1, {31'h0, irq});
        ahb(1'b1, ADDR_STATUS, 32'h20);
        cnt(2);
        chk("irq clr", 32'h0, {31'h0, irq});
        ahb(1'b0, 12'h010, 32'h0);
        chk("unmapped", 32'h0, rd);
        // Control bit must hold rf off while enable stays up
        ahb(1'b1, ADDR_CTRL, 32'h1);
        ahb(1'b0, ADDR_CTRL, 32'h0);
        chk("ctrl", 32'h1, rd);
        cnt(6);
        chk("forced off", 32'h0, 32'(rfc));
        ahb(1'b1, ADDR_CTRL, 32'h0);
        ahb(1'b0, ADDR_STATUS, 32'h0);
        chk("rearm", 32'h20, rd);
        cnt(6);
        chk("rf again", 32'h1, {31'h0, rfc > 0});
        lfs_host_model_inst.pw_pulse(250);
        cnt(1);
        chk("emit long", 32'h1, {31'h0, emission_indicator});
        cnt(30);
        lfs_host_model_inst.pw_pulse(100);
        cnt(1);
        chk("emit short", 32'h0, {31'h0, emission_indicator});
    endtask
    task automatic give_verdict();
        $display("Comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial
    begin
        repeat (20000) @(posedge hclk);
        err_total++;
        give_verdict();
    end
    initial
    begin
        hresetn = 1'b0;
        hsel    = 1'b0;
        hwrite  = 1'b0;
        haddr   = 32'h0;
        hwdata  = 32'h0;
        htrans  = 2'h0;
        hsize   = 3'h2;
        flt     = 5'h00;
        normal();
        for (int i = 0; i < 6; i++)
        begin
            do_reset();
            flt <= fv[i];
            lfs_host_model_inst.set_enable(1'b1);
            cnt(100);
            flt <= 5'h00;
            cnt(240);
            chk("power falls", 32'(pv[i]), 32'(pf));
            chk("ready falls", 32'(rv[i]), 32'(rdf));
            chk("rf blocked", 32'h0, 32'(rfc));
            ahb(1'b0, ADDR_FAULTS, 32'h0);
            chk("faults", {27'h0, fv[i]}, rd);
            ahb(1'b1, ADDR_MASK, 32'h1F);
            cnt(2);
            chk("fault irq", 32'h1, {31'h0, irq});
            ahb(1'b1, ADDR_STATUS, 32'h1F);
            cnt(2);
            chk("fault irq clr", 32'h0, {31'h0, irq});
        end
        normal();
        give_verdict();
    end
endmodule
